// ### eipf_pin_functions.v
// External interrupt edge detection, reset-low output pin and timer 1 toggle output.
// Assumes pins are synchronous to clk_sys; control register images come from the CPU side.
//
// Function
// RULE1: Fourth input requests on falling edge, lowest priority
// RULE2: Fourth input falling edge wakes from power-down
// RULE3: Zero select set: falling edge only
// RULE4: Zero select clear: both edges request
// RULE5: One select set: falling edge only
// RULE6: One select clear: both edges request
// RULE7: Qualifying zero edge wakes from power-down
// RULE8: Qualifying one edge wakes from power-down
// RULE9: Reset-low pin drives 0 after reset
// RULE10: Software writes 1 before using pin input
// RULE11: Enabled toggle output is timer 1 overflow halved
// RULE12: Synchronise pins, sample-compare edges, sticky pending flags
`timescale 1ns/1ps
`include "eipf_defines.vh"

module eipf_pin_functions (
  input wire clk_sys,
  input wire arst_n,
  input wire ext_irq_zero_pin,
  input wire ext_irq_one_pin,
  input wire ext_irq_four_pin,
  input wire [7:0] timer_irq_control_reg,
  input wire [7:0] clock_output_control_reg,
  input wire power_down,
  input wire ack_zero,
  input wire ack_one,
  input wire ack_four,
  input wire rst_low_out_wr,
  input wire rst_low_out_data,
  input wire timer1_overflow,
  output reg pend_zero,
  output reg pend_one,
  output reg pend_four,
  output wire irq_req_zero,
  output wire irq_req_one,
  output wire irq_req_four,
  output wire [1:0] irq_grant_id,
  output wire irq_any,
  output reg wake_pulse,
  output reg reset_low_output_pin,
  output wire reset_low_output_pin_oe_n,
  output reg timer1_toggle_output
);

  // Overview of the datapath, one stage per clock:
  //   pin -> sync[0] -> sync[1] -> prev
  // An edge is seen when sync[1] and prev differ.
  // The qualified edge sets a sticky pending flag.
  // The same qualified edge gives a wake pulse in power-down.
  //
  // Latency from a pin change to a pending flag is three
  // clocks: two synchroniser stages and the flag register.
  // Pins must hold a level for at least one clock, or the
  // edge may be lost between two samples.
  //
  // Wake detection needs clk_sys running; a design whose
  // clock stops in power-down must add an asynchronous path
  // in front of this block.

  // Edge qualifier: falling always, rising only in both-edge mode
  function edge_hit;
    input [1:0] sync;
    input prev;
    input falling_only;
    begin
      edge_hit = (prev & ~sync[1]) | ((falling_only == `EIPF_MODE_BOTH) & ~prev & sync[1]);
    end
  endfunction

  reg [1:0] sync_zero;
  reg [1:0] sync_one;
  reg [1:0] sync_four;
  reg prev_zero;
  reg prev_one;
  reg prev_four;
  wire irq_zero_edge_select;
  wire irq_one_edge_select;
  wire timer1_toggle_out_enable;
  wire hit_zero;
  wire hit_one;
  wire hit_four;

  assign irq_zero_edge_select = timer_irq_control_reg[`EIPF_TCTL_ZERO_EDGE_BIT];
  assign irq_one_edge_select = timer_irq_control_reg[`EIPF_TCTL_ONE_EDGE_BIT];
  assign timer1_toggle_out_enable = clock_output_control_reg[`EIPF_CKO_T1_EN_BIT];

  // Synchroniser for input zero; reset high so an idle-high pin makes no false edge
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_zero <= `EIPF_SYNC_RESET;
    end else begin
      sync_zero <= {sync_zero[0], ext_irq_zero_pin}; // [RULE12]
    end
  end

  // Synchroniser for input one; same reset level as input zero
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_one <= `EIPF_SYNC_RESET;
    end else begin
      sync_one <= {sync_one[0], ext_irq_one_pin}; // [RULE12]
    end
  end

  // Synchroniser for input four; a pin held low at release edges once
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_four <= `EIPF_SYNC_RESET;
    end else begin
      sync_four <= {sync_four[0], ext_irq_four_pin}; // [RULE12]
    end
  end

  // Previous samples; only the second stage is read, never the first
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_zero <= `EIPF_PREV_RESET;
      prev_one <= `EIPF_PREV_RESET;
      prev_four <= `EIPF_PREV_RESET;
    end else begin
      prev_zero <= sync_zero[1]; // [RULE12]
      prev_one <= sync_one[1]; // [RULE12]
      prev_four <= sync_four[1]; // [RULE12]
    end
  end

  // Edge qualification per source mode
  assign hit_zero = edge_hit(sync_zero, prev_zero, irq_zero_edge_select); // [RULE3] [RULE4]
  assign hit_one = edge_hit(sync_one, prev_one, irq_one_edge_select); // [RULE5] [RULE6]
  assign hit_four = edge_hit(sync_four, prev_four, `EIPF_MODE_FALLING); // [RULE1]

  // Pending flag zero; a new edge wins over a same-cycle acknowledge
  // so that an edge arriving during service is never lost
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_zero <= `EIPF_PEND_RESET;
    end else begin
      pend_zero <= hit_zero | (pend_zero & ~ack_zero); // [RULE12]
    end
  end

  // Pending flag one; same set-wins policy
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_one <= `EIPF_PEND_RESET;
    end else begin
      pend_one <= hit_one | (pend_one & ~ack_one); // [RULE12]
    end
  end

  // Pending flag four; falling edges only reach it
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_four <= `EIPF_PEND_RESET;
    end else begin
      pend_four <= hit_four | (pend_four & ~ack_four); // [RULE12] [RULE1]
    end
  end

  // Request outputs are plain copies of the flags
  // Requests stay up until the CPU side acknowledges

  assign irq_req_zero = pend_zero;
  assign irq_req_one = pend_one;
  assign irq_req_four = pend_four;
  assign irq_any = pend_zero | pend_one | pend_four;
  // Fixed order among these three; fourth input always last
  // Limitation: priority against other sources lies outside this block
  assign irq_grant_id = pend_zero ? `EIPF_GRANT_ZERO :
                        (pend_one ? `EIPF_GRANT_ONE :
                        (pend_four ? `EIPF_GRANT_FOUR : `EIPF_GRANT_NONE)); // [RULE1]

  // Wake pulse while powered down; the clock must keep running for detection
  // One pulse per qualifying edge, same cycle as the pending flag rises
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wake_pulse <= `EIPF_WAKE_RESET;
    end else begin
      wake_pulse <= power_down & (hit_zero | hit_one | hit_four); // [RULE2] [RULE7] [RULE8]
    end
  end

  // Reset-low pin: output 0 after reset until software writes its latch
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reset_low_output_pin <= `EIPF_RST_LOW_OUT_RESET; // [RULE9]
    end else if (rst_low_out_wr) begin
      reset_low_output_pin <= rst_low_out_data;
    end
  end
  // Drive only while latch is 0; a 1 releases the pin for input use
  assign reset_low_output_pin_oe_n = reset_low_output_pin; // [RULE10]

  // Toggle per overflow gives half the overflow rate
  // Disabling freezes the pin at its present level rather than forcing it low
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer1_toggle_output <= `EIPF_TOGGLE_RESET;
    end else if (timer1_toggle_out_enable && timer1_overflow) begin
      timer1_toggle_output <= ~timer1_toggle_output; // [RULE11]
    end
  end

endmodule // eipf_pin_functions

// ### eipf_defines.vh
// Constants for the external interrupt pin function block.
// Included by eipf_pin_functions.v; definitions only.
`ifndef EIPF_DEFINES_VH
`define EIPF_DEFINES_VH

// Bit positions in the timer/interrupt control register image
`define EIPF_TCTL_ZERO_EDGE_BIT 0
`define EIPF_TCTL_ONE_EDGE_BIT 2
// Bit position in the clock-output control register image
`define EIPF_CKO_T1_EN_BIT 1
// Reset values
`define EIPF_RST_LOW_OUT_RESET 1'h0
`define EIPF_TOGGLE_RESET 1'h0
`define EIPF_SYNC_RESET 2'h3
`define EIPF_PREV_RESET 1'h1
`define EIPF_PEND_RESET 1'h0
`define EIPF_WAKE_RESET 1'h0
// Grant identifiers, zero first, fourth input last
`define EIPF_GRANT_ZERO 2'h0
`define EIPF_GRANT_ONE 2'h1
`define EIPF_GRANT_FOUR 2'h2
`define EIPF_GRANT_NONE 2'h3
// Edge mode encodings of the edge-select bits
`define EIPF_MODE_FALLING 1'h1
`define EIPF_MODE_BOTH 1'h0

`endif

// ### eipf_properties.sv
// Port checker for the pin function block.
// Assumes one clk_sys domain, bound by port names.
`timescale 1ns/1ps
module eipf_properties (
  input wire clk_sys, input wire arst_n, input wire ext_irq_four_pin, input wire power_down,
  input wire [7:0] clock_output_control_reg, input wire timer1_overflow, input wire ack_four,
  input wire rst_low_out_wr, input wire rst_low_out_data, input wire pend_zero, input wire pend_one,
  input wire pend_four, input wire [1:0] irq_grant_id, input wire wake_pulse,
  input wire reset_low_output_pin, input wire timer1_toggle_output
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Overflow that the enable lets through
  wire tq = timer1_overflow & clock_output_control_reg[1];
  chk_toggle_flip: assert property (tq |=> timer1_toggle_output != $past(timer1_toggle_output))
    else $error("toggle missed");
  chk_toggle_hold: assert property (!tq |=> $stable(timer1_toggle_output))
    else $error("toggle moved");
  chk_pend_sticky: assert property (pend_four && !ack_four |=> pend_four)
    else $error("pending lost");
  chk_four_falling: assert property ($rose(pend_four) |-> $past(ext_irq_four_pin, 4) && !$past(ext_irq_four_pin, 3))
    else $error("four without fall");
  chk_wake_cause: assert property (wake_pulse |-> $past(power_down) && (pend_zero | pend_one | pend_four))
    else $error("stray wake");
  chk_rlo_write: assert property (rst_low_out_wr |=> reset_low_output_pin == $past(rst_low_out_data))
    else $error("latch write");
  chk_grant_zero: assert property (pend_zero |-> irq_grant_id == 2'h0)
    else $error("grant zero");
  chk_grant_four: assert property (pend_four && !pend_zero && !pend_one |-> irq_grant_id == 2'h2)
    else $error("grant four");
  cov_wake: cover property (wake_pulse);
  cov_toggle: cover property (tq);
  cov_four: cover property ($rose(pend_four));
endmodule // eipf_properties
bind eipf_pin_functions eipf_properties u_chk (.*);

// ### eipf_pin_source.sv
// Far-side model: three idle-high interrupt sources.
// Assumes drive is called just after a clock edge.
`timescale 1ns/1ps
module eipf_pin_source (
  input wire clk_sys,
  output reg [2:0] pins
);
  initial pins = 3'h7;
  // Level held two cycles so no edge is too short to
  task drive(input integer i, input v);
    begin pins[i] = v; repeat (2) @(posedge clk_sys); #2; end
  endtask
endmodule // eipf_pin_source

// ### test_ext_irq_pin_functions.sv
// Self-checking bench for the pin function block.
// Assumes the pin source model and the bound checker.
`timescale 1ns/1ps
module test_ext_irq_pin_functions;
  reg clk_sys, arst_n, pd, wr, wd, ovf, w;
  reg [2:0] ack;
  reg [7:0] tcr, ccr;
  wire [2:0] pin, pend, req;
  wire [1:0] gid;
  wire wake, rlo, rlo_oe_n, tgl, any;
  integer fail_count, check_count;
  eipf_pin_source i_src (.clk_sys(clk_sys), .pins(pin));
  eipf_pin_functions i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ext_irq_zero_pin(pin[0]),
    .ext_irq_one_pin(pin[1]), .ext_irq_four_pin(pin[2]), .timer_irq_control_reg(tcr),
    .clock_output_control_reg(ccr), .power_down(pd), .ack_zero(ack[0]), .ack_one(ack[1]),
    .ack_four(ack[2]), .rst_low_out_wr(wr), .rst_low_out_data(wd), .timer1_overflow(ovf),
    .pend_zero(pend[0]), .pend_one(pend[1]), .pend_four(pend[2]), .irq_req_zero(req[0]),
    .irq_req_one(req[1]), .irq_req_four(req[2]), .irq_grant_id(gid), .irq_any(any),
    .wake_pulse(wake), .reset_low_output_pin(rlo),
    .reset_low_output_pin_oe_n(rlo_oe_n), .timer1_toggle_output(tgl));
  initial begin clk_sys = 1'h0; forever #12.5 clk_sys = ~clk_sys; end
  task cyc(input integer n); begin repeat (n) @(posedge clk_sys); #2; end endtask
  task check(input [8*5:1] what, input [1:0] seen, input [1:0] exp); begin
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  end endtask
  task close_out; begin
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  // One edge, then pending, wake and grant, then service it
  task edge_case(input integer i, input v, input e); begin
    w = 1'h0;
    i_src.drive(i, v);
    repeat (6) begin cyc(1); w = w | wake; end
    check("pend", pend[i], e);
    check("wake", w, e & pd);
    check("req", req[i], e);
    check("any", any, e);
    if (e) check("grant", gid, i[1:0]);
    ack[i] = 1'h1; cyc(1); ack = 3'h0; cyc(1);
    check("ack", pend[i], 2'h0);
    check("grant", gid, 2'h3);
  end endtask
  task t_reset; begin
    check("rlo", {rlo_oe_n, rlo}, 2'h0);
    wr = 1'h1; wd = 1'h1; cyc(1); wr = 1'h0; cyc(1); check("rlo", {rlo_oe_n, rlo}, 2'h3);
    $display("t_reset done");
  end endtask
  task t_edges; begin
    tcr = 8'h05; pd = 1'h1;
    edge_case(0, 0, 1); edge_case(0, 1, 0);
    edge_case(1, 0, 1); edge_case(1, 1, 0);
    edge_case(2, 0, 1); edge_case(2, 1, 0);
    tcr = 8'h00; pd = 1'h0;
    edge_case(0, 0, 1); edge_case(0, 1, 1);
    edge_case(1, 0, 1); edge_case(1, 1, 1);
    $display("t_edges done");
  end endtask
  task t_toggle; begin
    ccr = 8'h02; ovf = 1'h1; cyc(1); check("tgl", tgl, 2'h1); cyc(1); check("tgl", tgl, 2'h0);
    ccr = 8'h00; cyc(2); check("tgl", tgl, 2'h0); ovf = 1'h0;
    $display("t_toggle done");
  end endtask
  // Reset in mid-run clears pending, toggle and the reset-low latch
  task t_mid_reset; begin
    ccr = 8'h02; ovf = 1'h1; cyc(1); ovf = 1'h0; ccr = 8'h00; cyc(1);
    check("tgl", tgl, 2'h1);
    i_src.drive(0, 0); cyc(4);
    check("pend", pend[0], 2'h1);
    arst_n = 1'h0; #1;
    check("pend", pend[0], 2'h0);
    check("tgl", tgl, 2'h0);
    check("rlo", {rlo_oe_n, rlo}, 2'h0);
    i_src.drive(0, 1); arst_n = 1'h1; cyc(6);
    check("pend", pend[0], 2'h0);
    check("rlo", {rlo_oe_n, rlo}, 2'h0);
    $display("t_mid_reset done");
  end endtask
  initial begin
    {arst_n, pd, wr, wd, ovf, w, ack, tcr, ccr} = 0; fail_count = 0; check_count = 0;
    repeat (20) @(posedge clk_sys); #2; arst_n = 1'h1; cyc(2);
    t_reset; t_edges; t_toggle; t_mid_reset; close_out;
  end
endmodule // test_ext_irq_pin_functions
